/* File: verilog/wwdt_top.sv */
// windowed watchdog: control/status registers, countdown, reset pulse
// assumes classic wishbone master on mclk; rst is the system reset and
// por the power on/off reset; the pulse on reset_n resets the cpu outside
//
// Overview of operation
// - count steps down by one every 12288 machine cycles
// - active and count falls 40h to 3Fh: reset pin low about 30us
// - watchdog off after reset; once set, activation stays until reset
// - write with activation set and top bit clear forces a reset
// - halt while active resets at once; wait has no effect
// - always-on option makes watchdog active, ignoring activation bit
// - control holds activation bit 7, count 6:0, resets to 7Fh
// - flag bit 0 set by dog reset, cleared by writing 0 or power reset
// - without low-voltage-detector reset the status register is unused
`timescale 1ns/100ps
module wwdt_top
    import wwdt_pkg::*;
#(
    parameter int BLOCK = WWDT_BLOCK_CYCLES,
    parameter int PULSE = WWDT_PULSE_CYCLES,
    parameter bit HAS_LVD = 1'b1
) (
    // clock and resets
    input wire logic mclk,
    input wire logic rst,
    input wire logic por,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // cpu and option inputs
    input wire logic always_on,
    input wire logic halt_exec,
    input wire logic wait_mode,
    // reset pin and state
    output logic dog_reset_n,
    output logic watchdog_active
);
    logic activation_bit;
    logic [6:0] countdown;
    logic dog_reset_flag;
    logic tick;
    logic busy;
    logic [31:0] next_dat;

    initial begin
        if (BLOCK > 65536 || PULSE > 65535) begin
            $error("wwdt_top: counts too large");
        end
    end

    // bus decode: a request is answered one cycle after it is seen
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire hit_ctrl = (wb_adr_i[11:2] == {2'b00, WWDT_CTRL_ADDR[9:2]});
    wire hit_stat = (wb_adr_i[11:2] == {2'b00, WWDT_STAT_ADDR[9:2]});
    wire hit = hit_ctrl || hit_stat;
    wire lane0 = wb_sel_i[0];
    wire wr_ctrl = req && wb_we_i && hit_ctrl && lane0;
    wire wr_stat = req && wb_we_i && hit_stat && lane0;
    wire [7:0] wdat = wb_dat_i[7:0];

    // the option pin stands in for the activation bit
    assign watchdog_active = activation_bit || always_on;

    // countdown edge and forced reset sources
    wire [6:0] dec_count = countdown - 7'h01;
    // a reload in the tick cycle wins, so a timely refresh never trips
    wire roll = tick && !wr_ctrl && countdown[WWDT_TOP_BIT] &&
        !dec_count[WWDT_TOP_BIT];
    wire next_act = activation_bit || wdat[WWDT_ACT_BIT];
    wire sw_fire = wr_ctrl && (next_act || always_on) &&
        !wdat[WWDT_TOP_BIT];
    wire halt_fire = halt_exec && watchdog_active;
    // wait_mode is deliberately unused: the countdown keeps running
    wire dog_fire = (watchdog_active && roll) || sw_fire || halt_fire;

    wwdt_prescale #(
        .DIV(BLOCK)
    ) u_pre (
        .mclk(mclk),
        .rst(rst),
        .restart(wr_ctrl),
        .tick(tick)
    );

    wwdt_pulse #(
        .LEN(PULSE)
    ) u_pulse (
        .mclk(mclk),
        .rst(rst),
        .fire(dog_fire),
        .reset_n(dog_reset_n),
        .busy(busy)
    );

    // control register: activation is sticky until reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            activation_bit <= WWDT_CTRL_RST[WWDT_ACT_BIT];
            countdown <= WWDT_CTRL_RST[6:0];
        end else if (wr_ctrl) begin
            activation_bit <= next_act;
            countdown <= wdat[6:0];
        end else if (tick) begin
            countdown <= dec_count;
        end
    end

    // flag survives the watchdog's own reset; only por or a write of 0 clears
    // it, and a new event in the write cycle wins
    always_ff @(posedge mclk) begin
        if (por || !HAS_LVD) begin
            dog_reset_flag <= 1'b0;
        end else if (dog_fire) begin
            dog_reset_flag <= 1'b1;
        end else if (wr_stat) begin
            dog_reset_flag <= wdat[WWDT_FLAG_BIT];
        end
    end

    // read mux, bits above the byte read as zero
    always_comb begin
        next_dat = '0;
        if (hit_ctrl) begin
            next_dat[7:0] = {activation_bit, countdown};
        end else if (hit_stat) begin
            next_dat[WWDT_FLAG_BIT] = dog_reset_flag;
        end
    end

    // one-cycle answer; unmapped addresses get err
    always_ff @(posedge mclk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req && hit;
            wb_err_o <= req && !hit;
            wb_dat_o <= next_dat;
        end
    end
endmodule

/* File: verilog/wwdt_pkg.sv */
// package for the windowed watchdog: register offsets, fields, timing
// assumes an 8-bit register map reached over classic wishbone
package wwdt_pkg;
    // register byte offsets (word aligned on the 32-bit bus)
    localparam logic [7:0] WWDT_CTRL_IDX = 8'h2a;
    localparam logic [9:0] WWDT_CTRL_ADDR = {WWDT_CTRL_IDX, 2'b00};
    localparam logic [9:0] WWDT_STAT_ADDR = 10'h0ac;
    // control and status fields and reset values
    localparam int WWDT_ACT_BIT = 7;
    localparam int WWDT_TOP_BIT = 6;
    localparam logic [7:0] WWDT_CTRL_RST = 8'h7f;
    localparam logic [7:0] WWDT_STAT_RST = 8'h00;
    localparam int WWDT_FLAG_BIT = 0;
    // timing
    localparam int WWDT_BLOCK_CYCLES = 12288;
    localparam int WWDT_CLK_MHZ = 25;
    localparam int WWDT_PULSE_NS = 30000;
    localparam int WWDT_PULSE_CYCLES = WWDT_PULSE_NS * WWDT_CLK_MHZ / 1000;
    typedef enum logic [1:0] {
        WWDT_IDLE,
        WWDT_PULSE
    } wwdt_state_t;
endpackage

/* File: verilog/wwdt_prescale.sv */
// divides the cpu clock into one-cycle ticks every block of machine cycles
// assumes one machine cycle per mclk edge
`timescale 1ns/100ps
module wwdt_prescale
    import wwdt_pkg::*;
#(
    parameter int DIV = WWDT_BLOCK_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // restart and tick
    input wire logic restart,
    output logic tick
);
    localparam int W = $clog2(DIV);
    logic [W-1:0] cnt;

    initial begin
        if (DIV < 2) begin
            $error("wwdt_prescale: DIV must be at least 2");
        end
    end

    // restarting on reload keeps each countdown step a full block long
    always_ff @(posedge mclk) begin
        if (rst || restart || tick) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end

    assign tick = (cnt == W'(DIV - 1));
endmodule

/* File: verilog/wwdt_pulse.sv */
// stretches a reset request into a low pulse of fixed length
// assumes the request is a one-cycle pulse
`timescale 1ns/100ps
module wwdt_pulse
    import wwdt_pkg::*;
#(
    parameter int LEN = WWDT_PULSE_CYCLES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // request and pin
    input wire logic fire,
    output logic reset_n,
    output logic busy
);
    localparam int W = $clog2(LEN + 1);
    wwdt_state_t state;
    logic [W-1:0] cnt;

    initial begin
        if (LEN < 1) begin
            $error("wwdt_pulse: LEN must be at least 1");
        end
    end

    // a new request during a pulse is absorbed by it
    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= WWDT_IDLE;
            cnt <= '0;
        end else begin
            case (state)
                WWDT_IDLE: begin
                    if (fire) begin
                        state <= WWDT_PULSE;
                        cnt <= W'(LEN - 1);
                    end
                end
                WWDT_PULSE: begin
                    if (cnt == '0) begin
                        state <= WWDT_IDLE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                default: state <= WWDT_IDLE;
            endcase
        end
    end

    assign busy = (state == WWDT_PULSE);
    assign reset_n = !busy;
endmodule

/* File: bench/wwdt_assertions.sv */
// checker for the watchdog top: bus answers, reset pin, activation
// assumes binding into wwdt_top with the short PULSE of 3 cycles
`timescale 1ns/100ps
module wwdt_chk
    import wwdt_pkg::*;
(
    // clock and resets
    input wire logic mclk, rst, por,
    // wishbone slave
    input wire logic wb_cyc_i, wb_stb_i, wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i, wb_dat_o,
    input wire logic wb_ack_o, wb_err_o,
    // cpu, option and pin
    input wire logic always_on, halt_exec, wait_mode,
    input wire logic dog_reset_n, watchdog_active
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // a new request and the two decoded places
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire hc = wb_adr_i[11:2] == {2'b00, WWDT_CTRL_ADDR[9:2]};
    wire hs = wb_adr_i[11:2] == {2'b00, WWDT_STAT_ADDR[9:2]};
    property p_ack; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("ack too long");
    property p_map; req && (hc || hs) |=> wb_ack_o && !wb_err_o; endproperty
    a_map: assert property (p_map) else $error("no ack");
    property p_err; req && !hc && !hs |=> wb_err_o && !wb_ack_o; endproperty
    a_err: assert property (p_err) else $error("no err");
    // pulse length fixed at three cycles in this bench
    property p_len;
        $fell(dog_reset_n) |-> !dog_reset_n[*3] ##1 dog_reset_n;
    endproperty
    a_len: assert property (p_len) else $error("bad pulse");
    property p_sw;
        req && hc && wb_we_i && wb_sel_i[0] && !wb_dat_i[6] &&
            (wb_dat_i[7] || watchdog_active)
            |-> ##[1:3] !dog_reset_n;
    endproperty
    a_sw: assert property (p_sw) else $error("no soft reset");
    property p_halt; halt_exec && watchdog_active |-> ##[1:3] !dog_reset_n;
    endproperty
    a_halt: assert property (p_halt) else $error("no halt reset");
    property p_on; always_on |-> watchdog_active; endproperty
    a_on: assert property (p_on) else $error("option ignored");
    property p_stk; watchdog_active && !always_on |=> watchdog_active;
    endproperty
    a_stk: assert property (p_stk) else $error("active lost");
endmodule
bind wwdt_top wwdt_chk u_chk (.*);

/* File: bench/wwdt_tb.sv */
// self-checking bench for the watchdog top over classic wishbone
// assumes short counts: BLOCK of 8 cycles, PULSE of 3 cycles
`timescale 1ns/100ps
module tb;
    import wwdt_pkg::*;
    localparam int BLK = 8;
    localparam logic [11:0] CA = {2'b00, WWDT_CTRL_ADDR};
    localparam logic [11:0] SA = {2'b00, WWDT_STAT_ADDR};
    logic mclk = 0, rst = 1, por = 1, wb_cyc_i = 0, wb_stb_i = 0;
    logic wb_we_i = 0, always_on = 0, halt_exec = 0, wait_mode = 0;
    logic [11:0] wb_adr_i = 0;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, seed = 32'h0f3a;
    logic wb_ack_o, wb_err_o, dog_reset_n, watchdog_active, ge;
    logic [7:0] exp_q[$];
    int err_total = 0, total_checks = 0, n;
    wwdt_top #(.BLOCK(BLK), .PULSE(3)) u_dut (.mclk, .rst, .por,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .wb_err_o, .always_on, .halt_exec,
        .wait_mode, .dog_reset_n, .watchdog_active);
    // 25 mhz clock
    always #20 mclk = ~mclk;
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    // one classic cycle; ack is taken at the edge where it is seen high
    task automatic wb(input logic [11:0] a, input logic w, logic [7:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'b11, w, a};
        {wb_sel_i, wb_dat_i} <= {4'h1, 24'h0, d};
        do begin
            @(posedge mclk);
            k++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && k < 20);
        ge = wb_err_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        wb(a, 0, 0);
    endtask
    // cycles until the pin goes low, capped at 100
    task automatic wlow();
        n = 0;
        while (dog_reset_n !== 1'b0 && n < 100) begin
            @(posedge mclk);
            n++;
        end
    endtask
    // read data is compared against the oldest note
    always @(posedge mclk)
        if (wb_ack_o === 1'b1 && !wb_we_i)
            chk(wb_dat_o[7:0], exp_q.pop_front());
    task automatic end_sim;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge mclk);
        err_total++;
        end_sim;
    end
    initial begin
        repeat (4) @(posedge mclk);
        {rst, por} <= 2'b00;
        rd(CA, WWDT_CTRL_RST);
        rd(SA, WWDT_STAT_RST);
        wb(12'h0b0, 0, 0);
        chk({7'h0, ge}, 1);
        wb(CA, 1, 8'h41);
        wlow();
        chk({7'h0, n >= 100}, 1);
        $display("test 1 done");
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wb(CA, 1, {2'b11, seed[5:0]});
            rd(CA, {2'b11, seed[5:0]});
        end
        wb(CA, 1, 8'hc1);
        wlow();
        chk({7'h0, n >= 2 * BLK - 1 && n <= 2 * BLK + 4}, 1);
        repeat (5) @(posedge mclk);
        rd(SA, 8'h01);
        wb(SA, 1, 0);
        rd(SA, 0);
        wb(CA, 1, 0);
        wlow();
        chk({7'h0, n < 8}, 1);
        rd(CA, 8'h80);
        repeat (5) @(posedge mclk);
        por <= 1;
        @(posedge mclk);
        por <= 0;
        rd(SA, 0);
        $display("test 2 done");
        for (int i = 1; i >= 0; i--) begin
            {rst, always_on, wait_mode} <= {2'b11, i[0]};
            repeat (4) @(posedge mclk);
            rst <= 0;
            always_on <= i[0];
            @(posedge mclk);
            halt_exec <= 1;
            @(posedge mclk);
            halt_exec <= 0;
            chk({7'h0, watchdog_active}, i);
            wlow();
            chk({7'h0, n < 4}, i);
            repeat (5) @(posedge mclk);
        end
        $display("test 3 done");
        end_sim;
    end
endmodule
